/* File: gpc_pkg.sv */
`default_nettype none

package gpc_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] GPC_OFF_PAD_SAMPLE  = 8'h00; // Pad levels, write-one toggles
    localparam logic [7:0] GPC_OFF_DIR         = 8'h04; // Direction bits
    localparam logic [7:0] GPC_OFF_OUT_VALUE   = 8'h08; // Output value / pull-up select
    localparam logic [7:0] GPC_OFF_CPU_CONTROL = 8'h0C; // Global control bits

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int         GPC_POS_PULLUP_GLOBAL_OFF = 0;     // Bit in cpu_control_reg
    localparam logic [7:0] GPC_RST_DIR               = 8'h00; // All inputs
    localparam logic [7:0] GPC_RST_OUT_VALUE         = 8'h00; // No pull-ups, drive low
    localparam logic       GPC_RST_PULLUP_GLOBAL_OFF = 1'b0;  // Pull-ups allowed

    // ----------------------------------------------------------------
    // Timing counts
    // ----------------------------------------------------------------
    localparam logic [1:0] GPC_WAKE_WINDOW = 2'h3; // Cycles to watch after clamp release

    // ----------------------------------------------------------------
    // Bus response codes
    // ----------------------------------------------------------------
    localparam logic [1:0] GPC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] GPC_RESP_SLVERR = 2'h2;

endpackage : gpc_pkg

`default_nettype wire

/* File: gpc_pin_control.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Pin-input write one toggles output value
// - Output direction drives pad from value
// - Input with value one enables pull-up
// - Global disable kills all pull-ups
// - Pad level readable in any direction
// - Latch transparent while clock high
// - Latched value loads on rising edge
// - Driven value reads back one clock later
// - Deep sleep clamps inputs to ground
// - Enabled external interrupts escape the clamp
// - Clamp release sets pending edge flag
// - Reset switches enabled pull-ups off
// - Reset floats every pin
// - Four byte registers per port
module gpc_pin_control
    import gpc_pkg::*;
#(
    parameter int PINS = 8
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // AXI4-Lite write address
    input  wire logic [7:0]      s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]      s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    // Pads
    input  wire logic [PINS-1:0] pad_in,
    output logic [PINS-1:0]      pad_out,
    output logic [PINS-1:0]      pad_oe,
    output logic [PINS-1:0]      pad_pullup,
    // Sleep controller and external interrupt unit
    input  wire logic            deep_sleep,
    input  wire logic [PINS-1:0] ext_int_enable,
    input  wire logic [PINS-1:0] ext_int_edge_sense,
    output logic [PINS-1:0]      ext_int_flag_set
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [PINS-1:0] dir_reg;            // Direction, one is output
    logic [PINS-1:0] out_value_reg;      // Drive value or pull-up select
    logic            pullup_global_off;  // Kills every pull-up
    logic [PINS-1:0] pad_sample_reg;     // Synchronised pad levels
    logic [PINS-1:0] pad_sample_q;       // Previous samples for edges
    logic [PINS-1:0] sync_latch;         // First synchroniser stage
    logic [PINS-1:0] pad_gated;          // Pad after sleep clamp
    logic [PINS-1:0] next_out_value;     // Output value after a write
    logic [PINS-1:0] next_dir;           // Direction after a write
    logic [7:0]      aw_addr;            // Held write address
    logic            aw_held;            // Write address taken
    logic [31:0]     w_data;             // Held write data
    logic [3:0]      w_strb;             // Held byte enables
    logic            w_held;             // Write data taken
    logic            wr_fire;            // Register write this cycle
    logic            wr_low_lane;        // Byte lane zero enabled
    logic            deep_sleep_q;       // Previous sleep level
    logic [1:0]      wake_cnt;           // Window after clamp release
    logic [31:0]     next_rdata;         // Read mux result
    logic [1:0]      next_rresp;         // Read response code

    assign wr_fire     = aw_held && w_held && !s_axi_bvalid;
    assign wr_low_lane = w_strb[0];

    // ----------------------------------------------------------------
    // Write channel capture
    // ----------------------------------------------------------------

    // Address and data taken in either order, held until response
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_held       <= 1'b0;
            aw_addr       <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            // Release when the write fires, in the cycle the response is raised
            if (wr_fire) begin
                aw_held <= 1'b0;
            end
            s_axi_awready <= !aw_held && !s_axi_bvalid;
        end
    end

    // Data channel mirrors the address channel
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else begin
            if (wr_fire) begin
                w_held <= 1'b0;
            end
            s_axi_wready <= !w_held && !s_axi_bvalid;
        end
    end

    // Write response, error for unmapped offsets
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= GPC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr == GPC_OFF_PAD_SAMPLE || aw_addr == GPC_OFF_DIR
                || aw_addr == GPC_OFF_OUT_VALUE || aw_addr == GPC_OFF_CPU_CONTROL) begin
                s_axi_bresp <= GPC_RESP_OKAY;
            end else begin
                s_axi_bresp <= GPC_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Port registers
    // ----------------------------------------------------------------

    // Next values of direction and output value
    always_comb begin
        next_dir       = dir_reg;
        next_out_value = out_value_reg;
        if (wr_fire && wr_low_lane) begin
            if (aw_addr == GPC_OFF_DIR) begin
                next_dir = w_data[PINS-1:0];
            end else if (aw_addr == GPC_OFF_OUT_VALUE) begin
                next_out_value = w_data[PINS-1:0];
            end else if (aw_addr == GPC_OFF_PAD_SAMPLE) begin
                next_out_value = out_value_reg ^ w_data[PINS-1:0];
            end
        end
    end

    // zero reset, load or toggle on write edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_reg       <= GPC_RST_DIR;
            out_value_reg <= GPC_RST_OUT_VALUE;
        end else begin
            dir_reg       <= next_dir;
            out_value_reg <= next_out_value;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pullup_global_off <= GPC_RST_PULLUP_GLOBAL_OFF;
        end else if (wr_fire && wr_low_lane && aw_addr == GPC_OFF_CPU_CONTROL) begin
            pullup_global_off <= w_data[GPC_POS_PULLUP_GLOBAL_OFF];
        end
    end

    // ----------------------------------------------------------------
    // Pad drivers
    // ----------------------------------------------------------------

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pad_oe     <= '0;
            pad_out    <= '0;
            pad_pullup <= '0;
        end else begin
            pad_oe     <= next_dir;
            pad_out    <= next_out_value;
            // pull-up for input with value one
            pad_pullup <= ~next_dir & next_out_value & {PINS{~pullup_global_off}};
        end
    end

    // ----------------------------------------------------------------
    // Input path
    // ----------------------------------------------------------------

    // Sleep clamp per pin, before the latch
    for (genvar i = 0; i < PINS; i++) begin : g_clamp
        assign pad_gated[i] = pad_in[i] & ~(deep_sleep & ~ext_int_enable[i]);
    end

    // latch open while clock high
    // Non-blocking so the rising edge flop still reads the held value
    always_latch begin
        if (clk) begin
            sync_latch <= pad_gated;
        end
    end

    // driven level back one clock later
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pad_sample_reg <= '0;
            pad_sample_q   <= '0;
        end else begin
            pad_sample_reg <= sync_latch;
            pad_sample_q   <= pad_sample_reg;
        end
    end

    // ----------------------------------------------------------------
    // Wake edge reporting
    // ----------------------------------------------------------------

    // Window opened when the clamp lifts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            deep_sleep_q <= 1'b0;
            wake_cnt     <= 2'h0;
        end else begin
            deep_sleep_q <= deep_sleep;
            if (deep_sleep_q && !deep_sleep) begin
                wake_cnt <= GPC_WAKE_WINDOW;
            end else if (wake_cnt != 2'h0) begin
                wake_cnt <= wake_cnt - 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_int_flag_set <= '0;
        end else if (wake_cnt != 2'h0) begin
            ext_int_flag_set <= pad_sample_reg & ~pad_sample_q
                                & ext_int_edge_sense & ~ext_int_enable;
        end else begin
            ext_int_flag_set <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = GPC_RESP_OKAY;
        if (s_axi_araddr == GPC_OFF_PAD_SAMPLE) begin
            next_rdata[PINS-1:0] = pad_sample_reg;
        end else if (s_axi_araddr == GPC_OFF_DIR) begin
            next_rdata[PINS-1:0] = dir_reg;
        end else if (s_axi_araddr == GPC_OFF_OUT_VALUE) begin
            next_rdata[PINS-1:0] = out_value_reg;
        end else if (s_axi_araddr == GPC_OFF_CPU_CONTROL) begin
            next_rdata[GPC_POS_PULLUP_GLOBAL_OFF] = pullup_global_off;
        end else begin
            // Unmapped offset
            next_rresp = GPC_RESP_SLVERR;
        end
    end

    // Read answer one cycle after address taken
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= GPC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end else if (s_axi_rvalid) begin
            // Hold data until the master takes it
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : gpc_pin_control

`default_nettype wire

/* File: gpc_checker.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Port checks for the pin block
// ----------------------------------------------------------------
module gpc_checker #(
    parameter int PINS = 8
) (
    // Clock, reset and bus
    input wire logic            clk,
    input wire logic            rst_n,
    input wire logic [7:0]      s_axi_araddr,
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic [31:0]     s_axi_rdata,
    input wire logic [1:0]      s_axi_rresp,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready,
    input wire logic [1:0]      s_axi_bresp,
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_bready,
    // Pads and sleep
    input wire logic [PINS-1:0] pad_out,
    input wire logic [PINS-1:0] pad_oe,
    input wire logic [PINS-1:0] pad_pullup,
    input wire logic            deep_sleep,
    input wire logic [PINS-1:0] ext_int_enable,
    input wire logic [PINS-1:0] ext_int_edge_sense,
    input wire logic [PINS-1:0] ext_int_flag_set
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] wake_age; // Cycles since leaving sleep, saturating
    // Age counter restarts when sleep ends
    always_ff @(posedge clk) begin
        if (!rst_n) wake_age <= 4'hF;
        else if ($fell(deep_sleep)) wake_age <= 4'h0;
        else if (wake_age != 4'hF) wake_age <= wake_age + 4'h1;
    end
    a_oe_blocks_pullup: assert property ((pad_oe & pad_pullup) == '0)
        else $error("pull-up on a driven pin");
    a_reset_release_float: assert property ($rose(rst_n) |-> pad_oe == '0 && pad_pullup == '0)
        else $error("pins not floating after reset");
    a_flag_not_enabled: assert property ((ext_int_flag_set & ext_int_enable) == '0)
        else $error("wake flag on an enabled pin");
    a_flag_needs_sense: assert property ((ext_int_flag_set & ~ext_int_edge_sense) == '0)
        else $error("wake flag on a level pin");
    a_flag_after_wake: assert property (|ext_int_flag_set |-> wake_age <= 4'h5)
        else $error("wake flag outside wake window");
    a_pads_on_write: assert property (($changed(pad_out) || $changed(pad_oe))
        |-> $rose(s_axi_bvalid) || !$past(rst_n))
        else $error("pad change without a write");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0C
        |=> s_axi_rvalid && s_axi_rresp == 2'h2)
        else $error("unmapped read not refused");
endmodule : gpc_checker

bind gpc_pin_control gpc_checker #(.PINS(PINS)) i_chk (.clk, .rst_n, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .pad_out, .pad_oe, .pad_pullup, .deep_sleep, .ext_int_enable,
    .ext_int_edge_sense, .ext_int_flag_set);

`default_nettype wire

/* File: gpc_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Board side of the pads: drivers, pull-ups, floating lines
// ----------------------------------------------------------------
module gpc_pad_model (
    input wire logic       clk,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup,
    input wire logic [7:0] ext_en,  // Board drives the pin
    input wire logic [7:0] ext_val, // Level the board drives
    output logic [7:0]     pad_in
);
    logic flip = 1'b0; // Floating lines wander every cycle
    always @(posedge clk) flip <= ~flip;
    // pull-up gives defined level, else the line wanders
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                  | (~pad_oe & ~ext_en & (pad_pullup | {8{flip}}));
endmodule : gpc_pad_model

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import gpc_pkg::*;
    logic clk, rst_n, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, deep_sleep;
    logic [7:0] awa, ara, pad_in, pad_out, pad_oe, pad_pullup, ie, es, flag, ext_en, ext_val;
    logic [31:0] wd, rdat;
    logic [3:0] ws;
    logic [1:0] bresp, rresp;
    int error_cnt = 0;
    int total_checks = 0;
    gpc_pin_control #(.PINS(8)) i_dut (.clk, .rst_n, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .pad_in, .pad_out, .pad_oe,
        .pad_pullup, .deep_sleep, .ext_int_enable(ie), .ext_int_edge_sense(es),
        .ext_int_flag_set(flag));
    gpc_pad_model i_pads (.clk, .pad_out, .pad_oe, .pad_pullup, .ext_en, .ext_val, .pad_in);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Bus write: address and data offered together, response awaited
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
        @(posedge clk);
        awa <= a; awv <= 1'b1; wd <= {24'h0, d}; ws <= s; wv <= 1'b1; br <= 1'b1;
        do begin
            @(posedge clk);
            if (awr && awv) awv <= 1'b0;
            if (wr_rdy && wv) wv <= 1'b0;
        end while (bv !== 1'b1);
        br <= 1'b0;
    endtask : wr
    // Bus read: returns data and response code
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        do begin
            @(posedge clk);
            if (arr && arv) arv <= 1'b0;
        end while (rv !== 1'b1);
        d = rdat; r = rresp; rr <= 1'b0;
    endtask : rd
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    // Reset values of pads and registers
    task automatic t_reset();
        logic [31:0] d; logic [1:0] r;
        #1; chk(pad_oe, 8'h00);
        chk(pad_pullup, 8'h00);
        rd(GPC_OFF_DIR, d, r); chk(d, 32'h0);
        rd(GPC_OFF_OUT_VALUE, d, r); chk(d, 32'h0);
    endtask : t_reset
    // Drive, pull-up and global pull-up disable
    task automatic t_config();
        logic [31:0] d; logic [1:0] r;
        // reach driven-high through the pull-up state
        wr(GPC_OFF_OUT_VALUE, 8'hA5); wr(GPC_OFF_DIR, 8'h0F); #1;
        chk(pad_oe, 8'h0F);
        chk(pad_out & 8'h0F, 8'h05);
        chk(pad_pullup, 8'hA0);
        rd(GPC_OFF_PAD_SAMPLE, d, r); chk(d & 32'hA5, 32'hA5);
        wr(GPC_OFF_CPU_CONTROL, 8'h01); @(posedge clk); #1;
        chk(pad_pullup, 8'h00);
        rd(GPC_OFF_CPU_CONTROL, d, r);
        chk(d, 32'h1);
        wr(GPC_OFF_CPU_CONTROL, 8'h00);
    endtask : t_config
    // Toggle writes, masked write, readback of driven pins
    task automatic t_toggle();
        logic [31:0] d; logic [1:0] r;
        // pins 5 and 7 leave pull-up via driven-high, then the toggle takes pins 7 and 0 low
        wr(GPC_OFF_DIR, 8'hFF); wr(GPC_OFF_PAD_SAMPLE, 8'h81);
        rd(GPC_OFF_OUT_VALUE, d, r); chk(d, 32'h24);
        wr(GPC_OFF_OUT_VALUE, 8'hFF, 4'h0);
        // read back only after an idle cycle past the write
        rd(GPC_OFF_PAD_SAMPLE, d, r); chk(d, 32'h24);
        #1; chk(pad_out, 8'h24);
    endtask : t_toggle
    // Unmapped place refused without side effect
    task automatic t_unmapped();
        logic [31:0] d; logic [1:0] r;
        wr(8'h10, 8'h00); chk(bresp, GPC_RESP_SLVERR);
        rd(8'h10, d, r); chk(r, GPC_RESP_SLVERR);
        rd(GPC_OFF_DIR, d, r); chk(d, 32'hFF);
    endtask : t_unmapped
    // Sleep clamp and wake flag
    task automatic t_sleep();
        logic [31:0] d; logic [1:0] r; logic [7:0] seen;
        wr(GPC_OFF_DIR, 8'h00); wr(GPC_OFF_OUT_VALUE, 8'h00);
        ext_en <= 8'hFF; ext_val <= 8'h03; ie <= 8'h01; es <= 8'h02; deep_sleep <= 1'b1;
        @(posedge clk);
        rd(GPC_OFF_PAD_SAMPLE, d, r); chk(d, 32'h01);
        deep_sleep <= 1'b0; seen = 8'h00;
        repeat (8) begin
            @(posedge clk);
            seen |= flag;
        end
        chk(seen, 8'h02);
        ext_en <= 8'h00;
    endtask : t_sleep
    // Reset in mid-run drops enabled pull-ups
    task automatic t_rst();
        wr(GPC_OFF_OUT_VALUE, 8'hA5);
        @(posedge clk); rst_n <= 1'b0;
        @(posedge clk); #1;
        chk(pad_pullup, 8'h00);
        chk(pad_oe, 8'h00);
        @(posedge clk); rst_n <= 1'b1;
    endtask : t_rst
    initial begin
        rst_n = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; awa = 0; ara = 0; wd = 0; ws = 0;
        deep_sleep = 0; ie = 0; es = 0; ext_en = 0; ext_val = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset(); t_config(); t_toggle(); t_unmapped(); t_sleep(); t_rst(); t_reset();
        summarize();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        summarize();
    end
endmodule : tb_top

`default_nettype wire
